// ---- hdl/lc_pkg.sv ----
// shared constants, register map and state codes of the curtain receiver controller
package lc_pkg;
  // clock and timing base
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYC_DFLT   = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_NS      = 100_000;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // times in milliseconds
  localparam int TEST_MIN_MS   = 50;
  localparam int RESET_MIN_MS  = 250;
  localparam int RESET_MAX_MS  = 2000;
  localparam int EDM_DROP_MS   = 200;
  localparam int PER_LO_MS     = 10;
  localparam int PER_HI_MS     = 27;
  localparam int SCAN_LO_MS    = 11;
  localparam int SCAN_HI_MS    = 56;
  localparam int R14_SYNC_LO   = 109;
  localparam int R14_SYNC_HI   = 800;
  localparam int R14_LO        = 33;
  localparam int R14_HI        = 220;
  localparam int R30_SYNC_LO   = 81;
  localparam int R30_SYNC_HI   = 495;
  localparam int R30_LO        = 25;
  localparam int R30_HI        = 152;
  // register byte offsets
  localparam logic [7:0] REG_CONFIG  = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_DISPLAY = 8'h08;
  localparam logic [7:0] REG_CONTROL = 8'h0C;
  // configuration fields
  localparam int CFG_SCAN      = 0;
  localparam int CFG_TL_A      = 1;
  localparam int CFG_TL_B      = 2;
  localparam int CFG_RR_A      = 3;
  localparam int CFG_RR_B      = 4;
  localparam int CFG_EDM_2CH   = 5;
  localparam int CFG_EDM_EN    = 6;
  localparam int CFG_RES30     = 7;
  localparam int CFG_BEAMS_LSB = 8;
  localparam int CFG_CASC      = 16;
  localparam logic [31:0] CFG_RST  = 32'h0000_1460;
  localparam int CTRL_SHOW     = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // status fields
  localparam int STS_TEST      = 5;
  localparam int STS_STOP      = 6;
  localparam int STS_SYNC      = 7;
  localparam int STS_ERR_LSB   = 8;
  localparam int STS_CNT_LSB   = 16;
  // error and glyph codes
  localparam logic [3:0] ERR_NONE   = 4'h0;
  localparam logic [3:0] ERR_SELF   = 4'h1;
  localparam logic [3:0] ERR_CFG    = 4'h2;
  localparam logic [3:0] ERR_EDM    = 4'h3;
  localparam logic [3:0] DIG_NORMAL = 4'hA;
  localparam logic [3:0] DIG_ERR    = 4'hE;
  typedef enum logic [4:0] {
    ST_LOCK  = 5'b00001,
    ST_WAIT  = 5'b00010,
    ST_BLOCK = 5'b00100,
    ST_RECOV = 5'b01000,
    ST_ON    = 5'b10000
  } state_t;
endpackage

// ---- hdl/lc_ms_tick.sv ----
// one-cycle tick every millisecond
`timescale 1ns/10ps
module lc_ms_tick #(
  parameter int unsigned CYCLES = 10000
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  logic [23:0] cnt_q;

  // free-running divider; tick stands one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 24'h00_0000;
      tick  <= 1'b0;
    end else if (cnt_q == 24'(CYCLES - 1)) begin
      cnt_q <= 24'h00_0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 24'h00_0001;
      tick  <= 1'b0;
    end
  end
endmodule

// ---- hdl/lc_hold_timer.sv ----
// millisecond hold counter for a level, saturating, cleared when the level drops
`timescale 1ns/10ps
module lc_hold_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        level,
  output logic      [11:0] held_ms
);
  // count stays readable in the cycle the level falls, cleared one edge later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_ms <= 12'h000;
    end else if (!level) begin
      held_ms <= 12'h000;
    end else if (tick && held_ms != 12'hFFF) begin
      held_ms <= held_ms + 12'h001;
    end
  end
endmodule

// ---- hdl/lc_receiver.sv ----
// light curtain receiver control: safety outputs, lockout, reset, test, indication
// Overview of operation
// (R1) a self-check failure stops both safety outputs and enters lockout
// (R2) lockout holds until the fault is gone and a valid reset pulse follows
// (R3) emitter test mode begins after test input low for 50 ms
// (R4) in test mode the emitter stops scanning its beams
// (R5) test mode ends as soon as the test input returns high
// (R6) reset acts only on a high pulse of 0.25 to 2 s then low
// (R7) two redundant safety outputs switch together
// (R8) outputs on are pulsed off 100 us, period 10 to 27 ms by beam count
// (R9) opened cascade stop contacts stop the outputs within 40 ms
// (R10) contact check: none, one or two channels, two by default
// (R11) monitored contacts must drop out within 200 ms of outputs off
// (R12) 14 mm recovery delay 109..800 ms after sync block, else 33..220 ms
// (R13) 30 mm recovery delay 81..495 ms after sync block, else 25..152 ms
// (R14) detection response time grows with the number of beams
// (R15) scan code selects code 1 or 2, code 1 at reset
// (R16) trip or latch behaviour chosen by a redundant switch pair
// (R17) reduced resolution chosen by a redundant pair, off at reset
// (R18) three-digit display shows normal, scan code, error or blocked count
// (R19) reset indicator shows ready or waiting for reset
// (R20) zone indicators show clear or blocked per beam group
// (R21) emitter status shows run, lockout or off, digit shows code or error; status is off (2'b00) only while reset, else run or lockout
// (R22) an object interrupting the curtain switches both outputs off
// (R23) a disagreeing redundant switch pair is a fault and locks out
`timescale 1ns/10ps
module lc_receiver #(
  parameter int unsigned MS_CYCLES = lc_pkg::MS_CYC_DFLT
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic      [1:0]  BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic      [31:0] RDATA,
  output logic      [1:0]  RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        SELF_CHECK_FAIL,
  input  wire logic        SYNC_BLOCKED,
  input  wire logic [7:0]  BLOCKED_COUNT,
  input  wire logic [3:0]  ZONE_BLOCKED,
  input  wire logic        RESET_INPUT,
  input  wire logic        TEST_INPUT,
  input  wire logic        CASCADE_STOP_INPUT,
  input  wire logic        CONTACT_CHECK_INPUT_A,
  input  wire logic        CONTACT_CHECK_INPUT_B,
  output logic             SAFETY_OUTPUT_A,
  output logic             SAFETY_OUTPUT_B,
  output logic             EMITTER_SCAN_EN,
  output logic             SCAN_CODE,
  output logic             RESET_INDICATOR,
  output logic      [3:0]  ZONE_CLEAR,
  output logic      [11:0] DIAG_DISPLAY,
  output logic      [1:0]  EMITTER_STATUS,
  output logic      [3:0]  EMITTER_DIGIT
);
  import lc_pkg::*;

  // linear interpolation between two figures over 0..255 beams
  function automatic logic [11:0] beam_scale(input int lo, input int hi, input logic [7:0] b);
    int v;
    v = lo + (((hi - lo) * int'(b)) >>> 8);
    return v[11:0];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == REG_CONFIG || a == REG_STATUS || a == REG_DISPLAY || a == REG_CONTROL;
  endfunction

  state_t      state_q, state_d;
  logic [31:0] cfg_q, ctrl_q;
  logic        tick, test_mode_q, rst_prev_q, detect_q, sync_was_q, bvalid_q, rvalid_q;
  logic [11:0] test_ms, rst_ms, edm_ms, rec_ms_q, scan_ms_q, per_ms_q, pulse_q, rec_limit;
  logic [3:0]  err_q;
  logic [7:0]  beams;
  logic        tl_latch, rr_on, cfg_bad, edm_bad, fault_any, rst_ok, stop_req, on_st;
  logic        casc_stop, blocked_raw, scan_tick, two_ch, contacts_ok;

  assign beams    = cfg_q[CFG_BEAMS_LSB +: 8];
  assign tl_latch = cfg_q[CFG_TL_A] & cfg_q[CFG_TL_B];                // [R16]
  assign rr_on    = cfg_q[CFG_RR_A] & cfg_q[CFG_RR_B];                // [R17]
  assign cfg_bad  = (cfg_q[CFG_TL_A] ^ cfg_q[CFG_TL_B]) |
                    (cfg_q[CFG_RR_A] ^ cfg_q[CFG_RR_B]);                // [R23]
  assign on_st    = state_q == ST_ON;

  lc_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .clk  (CLK),
    .rst  (SYS_RST),
    .tick (tick)
  );

  // held-time counters for test, reset and contact-check mismatch
  lc_hold_timer u_test (.clk(CLK), .rst(SYS_RST), .tick(tick), .level(!TEST_INPUT),
                        .held_ms(test_ms));
  lc_hold_timer u_rst (.clk(CLK), .rst(SYS_RST), .tick(tick), .level(RESET_INPUT),
                       .held_ms(rst_ms));
  lc_hold_timer u_edm (.clk(CLK), .rst(SYS_RST), .tick(tick), .level(edm_bad),
                       .held_ms(edm_ms));

  // contacts read high once the machine elements have dropped out
  assign two_ch      = cfg_q[CFG_EDM_2CH];                              // [R10]
  assign contacts_ok = two_ch ? (CONTACT_CHECK_INPUT_A & CONTACT_CHECK_INPUT_B)
                              : CONTACT_CHECK_INPUT_A;
  assign edm_bad     = cfg_q[CFG_EDM_EN] & ((!on_st & !contacts_ok) |
                       (two_ch & (CONTACT_CHECK_INPUT_A ^ CONTACT_CHECK_INPUT_B))); // [R11]
  assign fault_any   = SELF_CHECK_FAIL | cfg_bad | (edm_ms >= 12'(EDM_DROP_MS)); // [R1]

  // reset acts on the falling edge of a pulse of legal length
  assign rst_ok = rst_prev_q & !RESET_INPUT &
                  (rst_ms >= 12'(RESET_MIN_MS)) & (rst_ms <= 12'(RESET_MAX_MS)); // [R6]

  // a floating blanked beam is tolerated in reduced resolution
  assign blocked_raw = SYNC_BLOCKED | (BLOCKED_COUNT > (rr_on ? 8'h01 : 8'h00)); // [R22]
  assign casc_stop   = cfg_q[CFG_CASC] & !CASCADE_STOP_INPUT;          // [R9]
  assign stop_req    = detect_q | casc_stop;
  assign scan_tick   = tick && (scan_ms_q >= beam_scale(SCAN_LO_MS, SCAN_HI_MS, beams) - 12'h001);

  // recovery delay by resolution and whether the sync beam was lost
  always_comb begin
    if (cfg_q[CFG_RES30]) begin
      rec_limit = sync_was_q ? beam_scale(R30_SYNC_LO, R30_SYNC_HI, beams)
                             : beam_scale(R30_LO, R30_HI, beams);       // [R13]
    end else begin
      rec_limit = sync_was_q ? beam_scale(R14_SYNC_LO, R14_SYNC_HI, beams)
                             : beam_scale(R14_LO, R14_HI, beams);       // [R12]
    end
  end

  // curtain is evaluated once per scan, so longer curtains answer slower
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scan_ms_q <= 12'h000;
      detect_q  <= 1'b1;
    end else if (scan_tick) begin
      scan_ms_q <= 12'h000;
      detect_q  <= blocked_raw;                                         // [R14]
    end else if (tick) begin
      scan_ms_q <= scan_ms_q + 12'h001;
    end
  end

  // main sequence; a fault overrides every state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_LOCK: begin
        if (rst_ok) state_d = ST_BLOCK;                                 // [R2]
      end
      ST_WAIT: begin
        if (rst_ok) state_d = ST_BLOCK;
      end
      ST_BLOCK: begin
        if (!stop_req) state_d = ST_RECOV;
      end
      ST_RECOV: begin
        if (stop_req) state_d = ST_BLOCK;
        else if (rec_ms_q >= rec_limit) state_d = ST_ON;
      end
      ST_ON: begin
        if (stop_req) state_d = tl_latch ? ST_WAIT : ST_BLOCK;          // [R16]
      end
      default: state_d = ST_LOCK;
    endcase
    if (fault_any) state_d = ST_LOCK;                                   // [R1] [R2]
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ST_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // recovery timer and sync-loss memory; a sync block is recorded only outside the on state, and the on state clears it
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rec_ms_q   <= 12'h000;
      sync_was_q <= 1'b0;
      rst_prev_q <= 1'b0;
    end else begin
      rst_prev_q <= RESET_INPUT;
      if (state_q != ST_RECOV) rec_ms_q <= 12'h000;
      else if (tick && rec_ms_q != 12'hFFF) rec_ms_q <= rec_ms_q + 12'h001;
      if (SYNC_BLOCKED && !on_st) sync_was_q <= 1'b1;
      else if (on_st) sync_was_q <= 1'b0;
    end
  end

  // error code held for the display while locked out
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      err_q <= ERR_NONE;
    end else if (state_d == ST_LOCK && state_q != ST_LOCK) begin
      err_q <= SELF_CHECK_FAIL ? ERR_SELF : (cfg_bad ? ERR_CFG : ERR_EDM);
    end else if (state_q != ST_LOCK) begin
      err_q <= ERR_NONE;
    end
  end

  // emitter test mode: entry needs a held low, exit is immediate
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      test_mode_q <= 1'b0;
    end else if (TEST_INPUT) begin
      test_mode_q <= 1'b0;                                              // [R5]
    end else if (test_ms >= 12'(TEST_MIN_MS)) begin
      test_mode_q <= 1'b1;                                              // [R3]
    end
  end

  // self-test pulses: a then b dropped in turn, never both at once
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      per_ms_q <= 12'h000;
      pulse_q  <= 12'h000;
    end else if (!on_st) begin
      per_ms_q <= 12'h000;
      pulse_q  <= 12'h000;
    end else begin
      if (tick && per_ms_q >= beam_scale(PER_LO_MS, PER_HI_MS, beams) - 12'h001) begin
        per_ms_q <= 12'h000;
        pulse_q  <= 12'h001;                                            // [R8]
      end else begin
        if (tick) per_ms_q <= per_ms_q + 12'h001;
        if (pulse_q != 12'h000) begin
          pulse_q <= (pulse_q == 12'(2 * PULSE_CYC)) ? 12'h000 : pulse_q + 12'h001;
        end
      end
    end
  end

  // both outputs follow the on state together, apart from test pulses
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SAFETY_OUTPUT_A <= 1'b0;
      SAFETY_OUTPUT_B <= 1'b0;
    end else begin
      SAFETY_OUTPUT_A <= on_st & !(pulse_q != 12'h000 && pulse_q <= 12'(PULSE_CYC)); // [R7]
      SAFETY_OUTPUT_B <= on_st & !(pulse_q > 12'(PULSE_CYC));           // [R7]
    end
  end

  // indicators and displays
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RESET_INDICATOR <= 1'b0;
      ZONE_CLEAR      <= 4'h0;
      DIAG_DISPLAY    <= 12'h000;
      EMITTER_STATUS  <= 2'b00;
      EMITTER_DIGIT   <= 4'h0;
    end else begin
      RESET_INDICATOR <= state_q == ST_WAIT || state_q == ST_LOCK;      // [R19]
      ZONE_CLEAR      <= ~ZONE_BLOCKED;                                 // [R20]
      EMITTER_STATUS  <= (state_q == ST_LOCK) ? 2'b10 : 2'b01;          // [R21]
      if (state_q == ST_LOCK) begin
        DIAG_DISPLAY  <= {DIG_ERR, 4'h0, err_q};                        // [R18]
        EMITTER_DIGIT <= DIG_ERR;
      end else if (ctrl_q[CTRL_SHOW]) begin
        DIAG_DISPLAY  <= {8'h00, 3'b000, cfg_q[CFG_SCAN]} + 12'h001;
        EMITTER_DIGIT <= {3'b000, cfg_q[CFG_SCAN]} + 4'h1;              // [R21]
      end else if (BLOCKED_COUNT != 8'h00) begin
        DIAG_DISPLAY  <= {4'(BLOCKED_COUNT / 8'd100), 4'((BLOCKED_COUNT / 8'd10) % 8'd10),
                          4'(BLOCKED_COUNT % 8'd10)};                   // [R18]
        EMITTER_DIGIT <= DIG_NORMAL;
      end else begin
        DIAG_DISPLAY  <= {DIG_NORMAL, DIG_NORMAL, DIG_NORMAL};
        EMITTER_DIGIT <= DIG_NORMAL;
      end
    end
  end

  assign EMITTER_SCAN_EN = !test_mode_q;                                // [R4]
  assign SCAN_CODE       = cfg_q[CFG_SCAN];                             // [R15]

  // register bus: write address and data are taken together
  assign AWREADY = AWVALID & WVALID & !bvalid_q;
  assign WREADY  = AWREADY;
  assign ARREADY = !rvalid_q;
  assign BVALID  = bvalid_q;
  assign RVALID  = rvalid_q;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_q    <= CFG_RST;                                              // [R10] [R15] [R17]
      ctrl_q   <= CTRL_RST;
      bvalid_q <= 1'b0;
      BRESP    <= 2'b00;
    end else if (AWREADY) begin
      bvalid_q <= 1'b1;
      BRESP    <= mapped(AWADDR) ? 2'b00 : 2'b11;
      for (int i = 0; i < 4; i++) begin
        if (WSTRB[i] && AWADDR == REG_CONFIG) cfg_q[8*i +: 8] <= WDATA[8*i +: 8];
        if (WSTRB[i] && AWADDR == REG_CONTROL) ctrl_q[8*i +: 8] <= WDATA[8*i +: 8];
      end
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rvalid_q <= 1'b0;
      RDATA    <= 32'h0000_0000;
      RRESP    <= 2'b00;
    end else if (ARVALID && ARREADY) begin
      rvalid_q <= 1'b1;
      RRESP    <= mapped(ARADDR) ? 2'b00 : 2'b11;
      case (ARADDR)
        REG_CONFIG:  RDATA <= cfg_q;
        REG_STATUS:  RDATA <= {8'h00, BLOCKED_COUNT, 4'h0, err_q, sync_was_q, stop_req,
                               test_mode_q, state_q};
        REG_DISPLAY: RDATA <= {20'h0_0000, DIAG_DISPLAY};
        REG_CONTROL: RDATA <= ctrl_q;
        default:     RDATA <= 32'h0000_0000;
      endcase
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_lock_stop;
    SELF_CHECK_FAIL |-> ##2 (state_q == ST_LOCK && !SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B);
  endproperty
  a_lock_stop: assert property (p_lock_stop) else $error("outputs not stopped on fault"); // [R1]
  property p_lock_hold;
    (state_q == ST_LOCK && SELF_CHECK_FAIL) |=> state_q == ST_LOCK;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout left with fault"); // [R2]
  property p_test_in;
    (!TEST_INPUT && test_ms >= 12'(TEST_MIN_MS)) |=> test_mode_q;
  endproperty
  a_test_in: assert property (p_test_in) else $error("test mode not entered"); // [R3]
  property p_test_scan;
    test_mode_q |-> !EMITTER_SCAN_EN;
  endproperty
  a_test_scan: assert property (p_test_scan) else $error("scanning in test mode"); // [R4]
  property p_test_out;
    TEST_INPUT |=> !test_mode_q;
  endproperty
  a_test_out: assert property (p_test_out) else $error("test mode not left"); // [R5]
  property p_rst_short;
    ((state_q == ST_WAIT || state_q == ST_LOCK) && rst_prev_q && !RESET_INPUT &&
     rst_ms < 12'(RESET_MIN_MS)) |=> (state_q == ST_WAIT || state_q == ST_LOCK);
  endproperty
  a_rst_short: assert property (p_rst_short) else $error("short reset accepted"); // [R6]
  property p_out_on;
    (SAFETY_OUTPUT_A || SAFETY_OUTPUT_B) |-> $past(on_st);
  endproperty
  a_out_on: assert property (p_out_on) else $error("output on outside on state"); // [R7]
  property p_pulse;
    (on_st && pulse_q == 12'h001) |=> !SAFETY_OUTPUT_A && SAFETY_OUTPUT_B;
  endproperty
  a_pulse: assert property (p_pulse) else $error("test pulse missing"); // [R8]
  property p_casc;
    (cfg_q[CFG_CASC] && !CASCADE_STOP_INPUT) |-> ##2 (!SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B);
  endproperty
  a_casc: assert property (p_casc) else $error("cascade stop ignored"); // [R9]
  property p_edm;
    (edm_ms >= 12'(EDM_DROP_MS)) |=> state_q == ST_LOCK;
  endproperty
  a_edm: assert property (p_edm) else $error("contact fault not locked out"); // [R11]
  property p_pair;
    cfg_bad |=> state_q == ST_LOCK;
  endproperty
  a_pair: assert property (p_pair) else $error("switch pair mismatch ignored"); // [R23]
  c_on: cover property (state_q == ST_RECOV ##1 state_q == ST_ON);
  c_lock: cover property (state_q == ST_LOCK ##1 state_q == ST_BLOCK);
  c_test: cover property ($rose(test_mode_q));
endmodule

// ---- verif/lc_contactor.sv ----
// contactor pair model with its dropped-out monitoring contacts
`timescale 1ns/10ps
module lc_contactor #(
  parameter int DROP = 1500
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic coil_a,
  input  wire logic coil_b,
  input  wire logic weld,
  output logic      drop_a,
  output logic      drop_b
);
  int cnt_a_q;
  int cnt_b_q;
  // armature falls only after a long dead coil, so test pulses never release it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_a_q <= DROP;
      cnt_b_q <= DROP;
    end else begin
      cnt_a_q <= coil_a ? 0 : (cnt_a_q < DROP ? cnt_a_q + 1 : DROP);
      cnt_b_q <= coil_b ? 0 : (cnt_b_q < DROP ? cnt_b_q + 1 : DROP);
    end
  end
  // a welded contact never reports dropped out
  assign drop_a = (cnt_a_q >= DROP) && !weld;
  assign drop_b = (cnt_b_q >= DROP) && !weld;
endmodule

// ---- verif/lc_receiver_tb_top.sv ----
// self-checking bench of the curtain receiver controller
`timescale 1ns/10ps
module lc_receiver_tb_top;
  import lc_pkg::*;
  localparam int MS = 100;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, m, e; logic [1:0] r;} row_t;
  logic        CLK, SYS_RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, SELF_CHECK_FAIL, SYNC_BLOCKED;
  logic        RESET_INPUT, TEST_INPUT, CASCADE_STOP_INPUT, CONTACT_CHECK_INPUT_A;
  logic        CONTACT_CHECK_INPUT_B, SAFETY_OUTPUT_A, SAFETY_OUTPUT_B, EMITTER_SCAN_EN;
  logic        SCAN_CODE, RESET_INDICATOR, weld;
  logic [7:0]  AWADDR, ARADDR, BLOCKED_COUNT;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0]  WSTRB, ZONE_BLOCKED, ZONE_CLEAR, EMITTER_DIGIT;
  logic [1:0]  BRESP, RRESP, EMITTER_STATUS, rs;
  logic [11:0] DIAG_DISPLAY;
  int          fail_count = 0, checks_done = 0, cyc = 0, t;
  // register map rows: write flag, address, data, read mask, expected, response
  row_t rows[9] = '{
    '{0, 8'h00, 0, 32'hFFFF_FFFF, 32'h0000_1460, 2'h0},
    '{1, 8'h0C, 1, 0, 0, 2'h0},
    '{0, 8'h0C, 0, 32'hFFFF_FFFF, 32'h0000_0001, 2'h0},
    '{1, 8'h04, 32'hFFFF_FFFF, 0, 0, 2'h0},
    '{0, 8'h04, 0, 32'h0000_001F, 32'h0000_0002, 2'h0},
    '{1, 8'h10, 1, 0, 0, 2'h3},
    '{0, 8'h10, 0, 32'hFFFF_FFFF, 0, 2'h3},
    '{1, 8'h00, 32'h0000_1461, 0, 0, 2'h0},
    '{0, 8'h00, 0, 32'hFFFF_FFFF, 32'h0000_1461, 2'h0}};

  lc_receiver #(.MS_CYCLES(MS)) i_lc_receiver (.*);
  lc_contactor i_lc_contactor (.clk(CLK), .rst(SYS_RST), .coil_a(SAFETY_OUTPUT_A),
    .coil_b(SAFETY_OUTPUT_B), .weld(weld), .drop_a(CONTACT_CHECK_INPUT_A),
    .drop_b(CONTACT_CHECK_INPUT_B));

  // 10 MHz clock
  initial begin
    CLK = 0;
    forever #50 CLK = ~CLK;
  end

  // hang guard, sized for the long reset presses
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 140000) begin
      fail_count++;
      final_report;
    end
  end

  task automatic chk(input logic [31:0] g, e, input string s);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic ms(input int n);
    repeat (n * MS) @(posedge CLK);
  endtask

  // bus write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do @(posedge CLK); while (!(AWREADY && WREADY));
    AWVALID <= 1'b0;
    WVALID <= 1'b0;
    do @(posedge CLK); while (!BVALID);
    r = BRESP;
    BREADY <= 1'b0;
    // one idle edge so a following call never re-raises a strobe in this step
    @(posedge CLK);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (!RVALID);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic sts(input logic [31:0] m, e);
    rd_reg(REG_STATUS, rd, rs);
    chk(rd & m, e, "status");
  endtask

  // operator press of n ms, then release
  task automatic press(input int n);
    RESET_INPUT <= 1'b1;
    ms(n);
    RESET_INPUT <= 1'b0;
    ms(1);
  endtask

  // counts cycles until output a reaches v; the hang guard bounds it
  task automatic wait_out(input logic v);
    t = 0;
    while (SAFETY_OUTPUT_A !== v) begin
      @(posedge CLK);
      t++;
    end
  endtask

  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, SELF_CHECK_FAIL, SYNC_BLOCKED, weld} = '0;
    {AWADDR, ARADDR, BLOCKED_COUNT, WDATA, RESET_INPUT} = '0;
    {WSTRB, ZONE_BLOCKED, TEST_INPUT, CASCADE_STOP_INPUT} = 10'h3C3;
    SYS_RST = 1;
    repeat (16) @(posedge CLK);
    SYS_RST <= 0;
    // indicator flop already loads the wait state at the first edge
    repeat (2) @(posedge CLK);
    chk(RESET_INDICATOR, 1, "wait ind");
    chk({SAFETY_OUTPUT_A, SAFETY_OUTPUT_B, EMITTER_SCAN_EN, SCAN_CODE}, 2, "pins");
    for (int i = 0; i < 9; i++) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rs);
      else rd_reg(rows[i].a, rd, rs);
      chk(rows[i].w ? 0 : rd & rows[i].m, rows[i].e, "reg");
      chk(rs, rows[i].r, "resp");
    end
    ms(1);
    chk({SCAN_CODE, EMITTER_DIGIT, DIAG_DISPLAY}, {1'b1, 4'h2, 12'h002}, "code");
    wr(REG_CONTROL, 0, rs);
    ZONE_BLOCKED <= 4'b0101;
    ms(15);
    chk(ZONE_CLEAR, 4'b1010, "zone");
    ZONE_BLOCKED <= 0;
    TEST_INPUT <= 0;
    ms(45);
    chk(EMITTER_SCAN_EN, 1, "test early");
    ms(10);
    chk(EMITTER_SCAN_EN, 0, "test on");
    TEST_INPUT <= 1;
    repeat (3) @(posedge CLK);
    chk(EMITTER_SCAN_EN, 1, "test off");
    wr(REG_CONFIG, 32'h0001_1462, rs);
    sts(32'h0F1F, 32'h0201);
    wr(REG_CONFIG, 32'h0001_1460, rs);
    SELF_CHECK_FAIL <= 1;
    repeat (3) @(posedge CLK);
    sts(32'h0F1F, 32'h0201);
    chk({EMITTER_STATUS, EMITTER_DIGIT, DIAG_DISPLAY}, 18'h2_EE02, "lock show");
    press(255);
    sts(32'h001F, 1);
    SELF_CHECK_FAIL <= 0;
    press(20);
    sts(32'h001F, 1);
    press(255);
    chk(RESET_INDICATOR, 0, "ready");
    wait_out(1);
    chk(t inside {[32*MS:800*MS]} && SAFETY_OUTPUT_B === 1, 1, "recov");
    wait_out(0);
    chk(t <= 27*MS && SAFETY_OUTPUT_B === 1, 1, "pulse gap");
    wait_out(1);
    chk(t inside {[PULSE_CYC:3*PULSE_CYC]}, 1, "pulse width");
    wr(REG_CONFIG, 32'h0001_1460, rs);
    CASCADE_STOP_INPUT <= 0;
    ms(40);
    chk({SAFETY_OUTPUT_A, SAFETY_OUTPUT_B}, 0, "cascade");
    ms(20);
    CASCADE_STOP_INPUT <= 1;
    wait_out(1);
    BLOCKED_COUNT <= 3;
    SYNC_BLOCKED <= 1;
    ms(15);
    chk({SAFETY_OUTPUT_A, SAFETY_OUTPUT_B, DIAG_DISPLAY}, 12'h003, "blocked");
    sts(32'h0080, 32'h0080);
    {SYNC_BLOCKED, BLOCKED_COUNT} <= 0;
    wait_out(1);
    chk(t inside {[95*MS:800*MS]}, 1, "sync recov");
    weld <= 1;
    BLOCKED_COUNT <= 3;
    ms(150);
    chk(RESET_INDICATOR, 0, "weld early");
    ms(80);
    sts(32'h0F1F, 32'h0301);
    final_report;
  end
endmodule
